/* common/lcc_flags_if.sv */
// Interface carrying flag state from the register file to the timer.
// Assumes both ends sit on the same clock.
interface lcc_flags_if;
  import lcc_pkg::*;
  logic              srcSel;
  logic              countEn;
  logic              masterEn;
  logic              rollover;
  logic              cycleStartTx;
  logic [OFS_W-1:0]  cycleOffset;
  logic [SECS_W-1:0] cycleCount;
  modport ctrl  (output srcSel, countEn, masterEn, input rollover, cycleStartTx, cycleOffset, cycleCount);
  modport timer (input srcSel, countEn, masterEn, output rollover, cycleStartTx, cycleOffset, cycleCount);
endinterface

/* common/lcc_pkg.sv */
// Package for the link control register bank with its cycle timer.
// Assumes a single 100 MHz clock domain and an AHB-Lite register bus.
package lcc_pkg;
  localparam int unsigned ADDR_W            = 8;
  localparam logic [7:0]  OFS_SET           = 8'hE0;
  localparam logic [7:0]  OFS_CLR           = 8'hE4;
  localparam logic [7:0]  OFS_STATUS        = 8'hE8;     // Timer status view
  localparam logic [7:0]  OFS_CTX_FILTER    = 8'hEC;     // Per-context sync filter bits
  localparam int unsigned BIT_SRC_SEL       = 22;
  localparam int unsigned BIT_CYC_MASTER    = 21;
  localparam int unsigned BIT_CNT_EN        = 20;
  localparam int unsigned BIT_PHY_RX        = 10;
  localparam int unsigned BIT_SELFID_RX     = 9;
  localparam int unsigned BIT_FILTER_LOCK   = 6;
  localparam logic [31:0] FLAG_MASK         = 32'h0070_0640;
  localparam logic [31:0] FLAG_RESET        = 32'h0000_0000;
  localparam int unsigned CYCLE_TICKS       = 3072;      // Link clock periods per cycle
  localparam int unsigned LINK_FREQ_KHZ     = 24576;
  localparam int unsigned SYS_FREQ_KHZ      = 100000;
  localparam int unsigned OFS_W             = 12;
  localparam int unsigned SECS_W            = 13;        // Cycle count field width
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'b10;
  // Phase accumulator step: link ticks per sys clock, scaled
  localparam logic [16:0] TICK_STEP         = 17'(LINK_FREQ_KHZ);
  localparam logic [16:0] TICK_MOD          = 17'(SYS_FREQ_KHZ);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } lcc_bus_state_t;
endpackage

/* hw/lcc_cycle_timer.sv */
// Cycle offset counter paced by a 24.576 MHz tick enable.
// Assumes the tick enable and external cycle input are synchronous pulses.
module lcc_cycle_timer
  import lcc_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   linkTick,
  input  wire logic   externalCycleInput,
  input  wire logic   isRoot,
  input  wire logic   rxCycleStart,
  input  wire logic [OFS_W-1:0] rxCycleOffset,
  lcc_flags_if.timer  flags
);
  import lcc_pkg::*;

  localparam logic [OFS_W-1:0] LAST_OFS = OFS_W'(CYCLE_TICKS - 1);

  logic [OFS_W-1:0]  offset;
  logic [SECS_W-1:0] count;
  logic              roll;
  logic              startTx;

  // Rollover follows the chosen source
  wire internalRoll = flags.countEn && linkTick && (offset == LAST_OFS);
  wire externalRoll = flags.countEn && externalCycleInput;
  wire next_roll    = flags.srcSel ? externalRoll : internalRoll;

  // Offset counter; holds when disabled, resynchronises from received starts
  always_ff @(posedge clk) begin
    if (!rstn) begin
      offset  <= '0;
      count   <= '0;
      roll    <= 1'b0;
      startTx <= 1'b0;
    end else begin
      roll    <= next_roll;
      startTx <= next_roll && flags.masterEn && isRoot;
      if (!isRoot && rxCycleStart) begin
        offset <= rxCycleOffset;
      end else if (next_roll) begin
        offset <= '0;
        count  <= count + 1'b1;
      end else if (flags.countEn && linkTick && !flags.srcSel) begin
        offset <= offset + 1'b1;
      end else if (flags.countEn && linkTick && offset != LAST_OFS) begin
        offset <= offset + 1'b1;
      end
      // No branch advances with countEn low
    end
  end

  assign flags.rollover     = roll;
  assign flags.cycleStartTx = startTx;
  assign flags.cycleOffset  = offset;
  assign flags.cycleCount   = count;
endmodule

/* hw/lcc_link_control.sv */
// Link control register bank with set/clear views and its cycle timer.
// Assumes one 100 MHz clock, AHB-Lite single word transfers, one slave.
//
// How it works
// - Set view and clear view of one register, both read current flags.
// - Reserved bits 31-23, 19-11, 8-7, 5-0 always read zero.
// - Source select set: timer rolls over on the external cycle input.
// - Source select clear: roll over after 3072 link clock periods.
// - Master flag set and root: send cycle start at each rollover.
// - Not root: accept received cycle starts to stay synchronised.
// - Overlong cycle event clears the cycle master flag.
// - Setting cycle master is ignored while overlong event stays set.
// - Count enable set: offset advances each link clock period, stopping at 3071 while source select is set.
// - Count enable clear: offset holds, except that a received cycle start loads it while not root.
// - PHY receive flag with request context on: PHY packets go there.
// - PHY receive flag never affects self-identification reception.
// - Self-ID receive flag set: self-identification packets are accepted.
// - Filter lock set forces every context's sync filter bit to one.
// - Filter lock clear leaves sync filter bits software writable.
//
// Local design decision: the AHB-Lite register port.
module lcc_link_control
  import lcc_pkg::*;
#(
  parameter int unsigned NUM_CTX = 4
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  hsel,
  input  wire logic [ADDR_W-1:0]     haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  externalCycleInput,
  input  wire logic                  isRoot,
  input  wire logic                  rxCycleStart,
  input  wire logic [OFS_W-1:0]      rxCycleOffset,
  input  wire logic                  overlongCycleEvent,
  input  wire logic                  rxPhyPacket,
  input  wire logic                  rxSelfIdPacket,
  input  wire logic                  requestContextEnable,
  output logic                       cycleStartTx,
  output logic                       phyPacketToContext,
  output logic                       selfIdAccept,
  output logic      [NUM_CTX-1:0]    perContextSyncFilter
);
  import lcc_pkg::*;

  initial begin
    if (NUM_CTX < 1 || NUM_CTX > 32) $error("NUM_CTX must be 1 to 32");
  end

  lcc_flags_if flagBus ();

  lcc_bus_state_t state;
  logic [ADDR_W-1:0]  addrQ;
  logic [31:0]        flags;
  logic [NUM_CTX-1:0] ctxFilter;
  logic [16:0]        tickAcc;
  logic               linkTick;
  logic               overlongPrev;
  logic [31:0]        rdata;
  logic               txQ;
  logic               phyQ;
  logic               selfIdQ;

  // Address phase decode
  wire addrPhase  = hsel && hready && htrans == HTRANS_NONSEQ;
  wire isWrite    = state == ST_WRITE;
  wire wrSet      = isWrite && addrQ == OFS_SET;
  wire wrClr      = isWrite && addrQ == OFS_CLR;
  wire wrCtx      = isWrite && addrQ == OFS_CTX_FILTER;
  wire overlongUp = overlongCycleEvent && !overlongPrev;

  // Flag update: clear, set, then hardware overrides
  wire [31:0] setBits   = wrSet ? (hwdata & FLAG_MASK) : 32'h0000_0000;
  wire [31:0] clrBits   = wrClr ? (hwdata & FLAG_MASK) : 32'h0000_0000;
  wire [31:0] clrEff    = clrBits & ~(32'h0000_0001 << BIT_FILTER_LOCK);
  wire [31:0] setEff    = overlongCycleEvent ? (setBits & ~(32'h0000_0001 << BIT_CYC_MASTER))
                                             : setBits;
  wire [31:0] afterSw   = ((flags & ~clrEff) | setEff) & FLAG_MASK;
  wire [31:0] next_flags = overlongUp ? (afterSw & ~(32'h0000_0001 << BIT_CYC_MASTER))
                                      : afterSw;

  // Per-context filter bits, forced while locked
  wire                lockOn        = flags[BIT_FILTER_LOCK];
  wire [NUM_CTX-1:0]  next_ctxFilter = lockOn ? {NUM_CTX{1'b1}}
                                     : (wrCtx ? hwdata[NUM_CTX-1:0] : ctxFilter);

  // Read mux; set and clear views return the same flags
  wire [31:0] statusWord = {7'h00, flagBus.cycleCount, flagBus.cycleOffset};
  wire [31:0] ctxWord    = 32'(ctxFilter);
  wire [31:0] next_rdata = (haddr == OFS_SET || haddr == OFS_CLR) ? flags
                         : (haddr == OFS_STATUS)     ? statusWord
                         : (haddr == OFS_CTX_FILTER) ? ctxWord
                         : 32'h0000_0000;

  // Link tick enable: 24.576 MHz average rate from the 100 MHz clock
  wire [16:0] accSum   = tickAcc + TICK_STEP;
  wire        accWrap  = accSum >= TICK_MOD;
  wire [16:0] next_acc = accWrap ? (accSum - TICK_MOD) : accSum;

  // Bus phase tracking; every transfer answers with zero wait states
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      addrQ <= '0;
    end else if (addrPhase) begin
      state <= hwrite ? ST_WRITE : ST_READ;
      addrQ <= haddr;
    end else begin
      state <= ST_IDLE;
    end
  end

  // Read data captured in the address phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (addrPhase && !hwrite) begin
      rdata <= next_rdata;
    end
  end

  // Flag and filter storage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags        <= FLAG_RESET;
      ctxFilter    <= '0;
      overlongPrev <= 1'b0;
    end else begin
      flags        <= next_flags;
      ctxFilter    <= next_ctxFilter;
      overlongPrev <= overlongCycleEvent;
    end
  end

  // Tick divider
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tickAcc  <= '0;
      linkTick <= 1'b0;
    end else begin
      tickAcc  <= next_acc;
      linkTick <= accWrap;
    end
  end

  // Receive gating; PHY flag never touches self-ID path
  always_ff @(posedge clk) begin
    if (!rstn) begin
      txQ     <= 1'b0;
      phyQ    <= 1'b0;
      selfIdQ <= 1'b0;
    end else begin
      txQ     <= flagBus.cycleStartTx;
      phyQ    <= rxPhyPacket && flags[BIT_PHY_RX] && requestContextEnable;
      selfIdQ <= rxSelfIdPacket && flags[BIT_SELFID_RX];
    end
  end

  assign flagBus.srcSel   = flags[BIT_SRC_SEL];
  assign flagBus.countEn  = flags[BIT_CNT_EN];
  assign flagBus.masterEn = flags[BIT_CYC_MASTER];

  lcc_cycle_timer u_timer (
    .clk                (clk),
    .rstn               (rstn),
    .linkTick           (linkTick),
    .externalCycleInput (externalCycleInput),
    .isRoot             (isRoot),
    .rxCycleStart       (rxCycleStart),
    .rxCycleOffset      (rxCycleOffset),
    .flags              (flagBus)
  );

  assign hrdata               = rdata;
  assign hreadyout            = 1'b1;   // Constant: never stalls
  assign hresp                = 1'b0;
  assign cycleStartTx         = txQ;
  assign phyPacketToContext   = phyQ;
  assign selfIdAccept         = selfIdQ;
  assign perContextSyncFilter = ctxFilter;
endmodule

/* tb/lcc_link_control_asserts.sv */
// Checker for the link control bank, port level only.
// Assumes one clock and a synchronous active low reset.
module lcc_link_control_asserts
  import lcc_pkg::*;
#(
  parameter int unsigned NUM_CTX = 4
) (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic               hsel,
  input wire logic [ADDR_W-1:0]  haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               isRoot,
  input wire logic               rxPhyPacket,
  input wire logic               rxSelfIdPacket,
  input wire logic               requestContextEnable,
  input wire logic               cycleStartTx,
  input wire logic               phyPacketToContext,
  input wire logic               selfIdAccept,
  input wire logic [NUM_CTX-1:0] perContextSyncFilter
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire taken = hsel && hready && htrans == HTRANS_NONSEQ;
  wire flagAddr = haddr == OFS_SET || haddr == OFS_CLR;
  logic       rdFlags;
  logic       wrSet;
  logic [1:0] lockAge;
  // Age of the lock write; holds at 3 until a new lock write restarts it at 1, so a later clear cannot hide
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdFlags <= 1'b0;
      wrSet   <= 1'b0;
      lockAge <= 2'd0;
    end else begin
      rdFlags <= taken && !hwrite && flagAddr;
      wrSet   <= taken && hwrite && haddr == OFS_SET;
      if (lockAge != 2'd0 && lockAge != 2'd3) lockAge <= lockAge + 2'd1;
      else if (wrSet && hwdata[BIT_FILTER_LOCK]) lockAge <= 2'd1;
    end
  end
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_stand; !(taken && !hwrite) |=> $stable(hrdata); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_rsvd; rdFlags |-> (hrdata & ~FLAG_MASK) == 32'h0000_0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_phy; phyPacketToContext |-> $past(rxPhyPacket) && $past(requestContextEnable); endproperty
  a_phy: assert property (p_phy) else $error("phy packet uncaused");
  property p_self; selfIdAccept |-> $past(rxSelfIdPacket); endproperty
  a_self: assert property (p_self) else $error("self id uncaused");
  property p_lock; lockAge == 2'd3 |-> &perContextSyncFilter; endproperty
  a_lock: assert property (p_lock) else $error("filter not forced");
  property p_root; cycleStartTx |-> $past(isRoot, 2); endproperty
  a_root: assert property (p_root) else $error("start while not root");
  property p_pulse; cycleStartTx |=> !cycleStartTx [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
endmodule
bind lcc_link_control lcc_link_control_asserts #(.NUM_CTX(NUM_CTX)) u_chk (.clk, .rstn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .isRoot, .rxPhyPacket, .rxSelfIdPacket,
  .requestContextEnable, .cycleStartTx, .phyPacketToContext, .selfIdAccept, .perContextSyncFilter);

/* tb/lcc_link_control_tb.sv */
// Bench for the link control bank: bus tasks and call sequences.
// Assumes the bank answers with no wait states on AHB-Lite.
module lcc_link_control_tb import lcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rstn = 0, hsel = 0, hwrite = 0, extIn = 0, isRoot = 0, rxStart = 0, ovl = 0, reqEn = 0;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0, pk = 0;
  logic [31:0] hwdata = 0, rdv, s1;
  wire  [31:0] hrdata;
  wire         hreadyout, cycleStartTx, phyOut, selfOut;
  wire  [3:0]  filt;
  int          err_count = 0, samples_checked = 0, cyc = 0, n;
  always #5 clk = ~clk;
  lcc_link_control #(.NUM_CTX(4)) DUT (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(1'b1), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(), .externalCycleInput(extIn), .isRoot(isRoot), .rxCycleStart(rxStart), .rxCycleOffset(12'h123),
    .overlongCycleEvent(ovl), .rxPhyPacket(pk[0]), .rxSelfIdPacket(pk[1]), .requestContextEnable(reqEn),
    .cycleStartTx(cycleStartTx), .phyPacketToContext(phyOut), .selfIdAccept(selfOut), .perContextSyncFilter(filt));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, well above the two timer cycles measured
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One single transfer; read data taken at the data phase edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(rdv, e);
  endtask
  // Gated outputs stand one cycle only: look mid-cycle while they stand
  task automatic pulse(input logic [1:0] p, input logic [1:0] e);
    pk <= p;
    @(posedge clk);
    pk <= 2'b00;
    @(negedge clk);
    chk({30'h0, selfOut, phyOut}, {30'h0, e});
    @(posedge clk);
  endtask
  // Counts cycles until a cycle start, giving up at lim
  task automatic waitStart(input int lim);
    n = 0;
    while (cycleStartTx !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(OFS_SET, 32'h0000_0000);
    bus(OFS_CTX_FILTER, 1'b1, 32'h0000_0005);
    rdc(OFS_CTX_FILTER, 32'h0000_0005);
    bus(OFS_SET, 1'b1, 32'hFFFF_FFFF);
    rdc(OFS_SET, FLAG_MASK);
    rdc(OFS_CLR, FLAG_MASK);
    bus(OFS_CLR, 1'b1, 32'hFFFF_FFFF);
    rdc(OFS_SET, 32'h0000_0040);
    bus(OFS_CTX_FILTER, 1'b1, 32'h0000_0000);
    rdc(OFS_CTX_FILTER, 32'h0000_000F);
    // Overlong event drops the master flag and blocks its set
    bus(OFS_SET, 1'b1, 32'h0020_0000);
    ovl <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(OFS_SET, 32'h0000_0040);
    bus(OFS_SET, 1'b1, 32'h0020_0000);
    rdc(OFS_SET, 32'h0000_0040);
    ovl <= 1'b0;
    bus(OFS_CLR, 1'b1, 32'h0000_0000);
    bus(OFS_SET, 1'b1, 32'h0020_0400);
    rdc(OFS_CLR, 32'h0020_0440);
    reqEn <= 1'b1;
    pulse(2'b10, 2'b00);
    pulse(2'b01, 2'b01);
    bus(OFS_SET, 1'b1, 32'h0000_0200);
    pulse(2'b10, 2'b10);
    bus(OFS_STATUS, 1'b0, 32'h0000_0000);
    s1 = rdv;
    repeat (50) @(posedge clk);
    rdc(OFS_STATUS, s1);
    isRoot <= 1'b1;
    bus(OFS_SET, 1'b1, 32'h0010_0000);
    waitStart(14000);
    @(posedge clk);
    waitStart(14000);
    chk({31'h0, n >= 12497 && n <= 12502}, 32'h0000_0001);
    bus(OFS_SET, 1'b1, 32'h0040_0000);
    waitStart(20);
    extIn <= 1'b1;
    @(posedge clk);
    extIn <= 1'b0;
    waitStart(6);
    chk({31'h0, n < 6}, 32'h0000_0001);
    isRoot <= 1'b0;
    rxStart <= 1'b1;
    @(posedge clk);
    rxStart <= 1'b0;
    bus(OFS_STATUS, 1'b0, 32'h0000_0000);
    chk({31'h0, rdv[11:0] - 12'h123 <= 12'h003}, 32'h0000_0001);
    tally_and_finish();
  end
endmodule
